// ---- inc/ppl_pkg.sv ----
// Purpose: Constants and carrier types for the parallel port pin logic
// Assumes: APB word registers, byte address = index * 4
// Notes:   Index bit 5 set selects the latch view of a data register
package ppl_pkg;
  localparam logic [5:0] IDX_PD0   = 6'h00;
  localparam logic [5:0] IDX_DIR0  = 6'h01;
  localparam logic [5:0] IDX_PD1   = 6'h02;
  localparam logic [5:0] IDX_DIR1  = 6'h03;
  localparam logic [5:0] IDX_PD2   = 6'h04;
  localparam logic [5:0] IDX_PD3   = 6'h0c;
  localparam logic [5:0] IDX_DIR3  = 6'h0d;
  localparam logic [5:0] IDX_PD4   = 6'h10;
  localparam logic [5:0] IDX_PD5   = 6'h11;
  localparam logic [5:0] IDX_PD6   = 6'h12;
  localparam logic [5:0] IDX_PD7   = 6'h13;
  localparam logic [5:0] IDX_BZR   = 6'h14;
  localparam logic [5:0] IDX_LVIEW = 6'h20;
  localparam logic [7:0] RST_DIR   = 8'h00;
  localparam logic [3:0] RST_PD2   = 4'h0;
  localparam logic [7:0] RST_HV    = 8'h00;
  localparam logic [2:0] RST_BZR   = 3'h0;
  localparam int         BZ_BASE   = 8;
  localparam int         BZ_CNT_W  = 16;
  localparam logic [1:0] P31_BIT   = 2'h1;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } ppl_drv_t;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] o;
  } ppl_res_t;
endpackage

// ---- src/ppl_top.sv ----
// Purpose: Pin logic of ports 0..7 and the buzzer pin, APB register slave
// Assumes: 200 MHz clk_i, synchronous active-high srst_i, pins asynchronous
// Notes:   Reads at index+0x20 of ports 0, 1 and 3 return latches (read-modify-write view)
// How it works
// - Each bidirectional bit has its own direction bit, 1 output, 0 input.
// - Input bits are tri-stated; data reads return the sampled pin level.
// - Read-modify-write reads return the output latch regardless of direction.
// - Data writes always update the output latch, input bits included.
// - Reset clears direction bits only; bidirectional latches keep their value.
// - Stop float with stop mode tri-states every port and buzzer output.
// - Output-only port reads return its latch.
// - Output-only port resets to 0, tri-stated until the reset vector fetch.
// - Input-only port is read-only pin level, no reset, oscillator pins option.
// - Peripheral output enable overrides the direction bit on shared pins, except the port 3 open-drain bit 1.
// - Port reads return peripheral output while the peripheral drives.
// - Pin level always goes to the peripheral input.
// - High-voltage port reads return the latch, never the pin.
// - Reset clears high-voltage latches, all transistors off.
// - Buzzer outputs a waveform chosen by its register; zero tri-states it.
// - Direction registers are write-only and read as zero.
`timescale 1ns/1ps
module ppl_top (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  // APB slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Standby and CPU
  input  wire logic                stop_float_bit_i,
  input  wire logic                stop_mode_i,
  input  wire logic                vector_fetch_i,
  input  wire logic                dual_clock_opt_i,
  // Bidirectional ports 0, 1, 3
  input  wire logic [7:0]          p0_in_i,
  input  wire logic [7:0]          p1_in_i,
  input  wire logic [7:0]          p3_in_i,
  output ppl_pkg::ppl_drv_t        p0_o,
  output ppl_pkg::ppl_drv_t        p1_o,
  output ppl_pkg::ppl_drv_t        p3_o,
  // Peripheral sharing on ports 0, 1, 3
  input  ppl_pkg::ppl_res_t        res0_i,
  input  ppl_pkg::ppl_res_t        res1_i,
  input  ppl_pkg::ppl_res_t        res3_i,
  output logic [7:0]               res0_in_o,
  output logic [7:0]               res1_in_o,
  output logic [7:0]               res3_in_o,
  // Output-only, high-voltage, input-only, buzzer
  output logic [3:0]               p2_o,
  output logic [3:0]               p2_oe_o,
  output ppl_pkg::ppl_drv_t        p4_o,
  output ppl_pkg::ppl_drv_t        p5_o,
  output ppl_pkg::ppl_drv_t        p6_o,
  input  wire logic [1:0]          p7_in_i,
  output logic [1:0]               sub_osc_o,
  output logic                     buzzer_pin_o,
  output logic                     buzzer_pin_oe_o
);
  logic [7:0]  dir0_ff, dir1_ff, dir3_ff, nxt_dir0, nxt_dir1, nxt_dir3;
  logic [7:0]  lat0_ff, lat1_ff, lat3_ff, nxt_lat0, nxt_lat1, nxt_lat3;
  logic [3:0]  lat2_ff, nxt_lat2;
  logic [7:0]  lat4_ff, lat5_ff, lat6_ff, nxt_lat4, nxt_lat5, nxt_lat6;
  logic [2:0]  bzr_ff, nxt_bzr;
  logic        fetched_ff, nxt_fetched;
  logic [ppl_pkg::BZ_CNT_W-1:0] bzc_ff, nxt_bzc;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        err_ff, nxt_err;
  logic [25:0] s1_ff, s2_ff;
  logic [7:0]  pin0, pin1, pin3;
  logic [1:0]  pin7;
  logic        float_en, wr, setup, bz_wave;
  logic [5:0]  idx;

  function automatic logic known_idx(input logic [5:0] i);
    unique case (i)
      ppl_pkg::IDX_PD0, ppl_pkg::IDX_DIR0, ppl_pkg::IDX_PD1, ppl_pkg::IDX_DIR1,
      ppl_pkg::IDX_PD2, ppl_pkg::IDX_PD3, ppl_pkg::IDX_DIR3, ppl_pkg::IDX_PD4,
      ppl_pkg::IDX_PD5, ppl_pkg::IDX_PD6, ppl_pkg::IDX_PD7, ppl_pkg::IDX_BZR: known_idx = 1'b1;
      default: known_idx = 1'b0;
    endcase
  endfunction

  // Read value of a shared bidirectional port
  function automatic logic [7:0] port_rd(input logic [7:0] pin, input ppl_pkg::ppl_res_t r);
    port_rd = (r.oe & r.o) | (~r.oe & pin);
  endfunction

  // Two flops on every pin input; only the second stage is read
  always_ff @(posedge clk_i) begin
    s1_ff <= {p7_in_i, p3_in_i, p1_in_i, p0_in_i};
    s2_ff <= s1_ff;
  end
  assign pin0 = s2_ff[7:0];
  assign pin1 = s2_ff[15:8];
  assign pin3 = s2_ff[23:16];
  assign pin7 = s2_ff[25:24];

  assign float_en = stop_float_bit_i & stop_mode_i;

  assign idx   = paddr_i[7:2];
  assign setup = psel_i & ~penable_i;
  assign wr    = psel_i & penable_i & pwrite_i & known_idx(idx);

  always_comb begin
    nxt_dir0    = dir0_ff;
    nxt_dir1    = dir1_ff;
    nxt_dir3    = dir3_ff;
    nxt_lat0    = lat0_ff;
    nxt_lat1    = lat1_ff;
    nxt_lat3    = lat3_ff;
    nxt_lat2    = lat2_ff;
    nxt_lat4    = lat4_ff;
    nxt_lat5    = lat5_ff;
    nxt_lat6    = lat6_ff;
    nxt_bzr     = bzr_ff;
    nxt_fetched = fetched_ff | vector_fetch_i;
    nxt_bzc     = bzc_ff + 1'b1;
    nxt_prdata  = prdata_ff;
    nxt_err     = err_ff;
    if (wr) begin
      unique case (idx)
        ppl_pkg::IDX_PD0:  nxt_lat0 = pwdata_i[7:0];
        ppl_pkg::IDX_DIR0: nxt_dir0 = pwdata_i[7:0];
        ppl_pkg::IDX_PD1:  nxt_lat1 = pwdata_i[7:0];
        ppl_pkg::IDX_DIR1: nxt_dir1 = pwdata_i[7:0];
        ppl_pkg::IDX_PD2:  nxt_lat2 = pwdata_i[3:0];
        ppl_pkg::IDX_PD3:  nxt_lat3 = pwdata_i[7:0];
        ppl_pkg::IDX_DIR3: nxt_dir3 = pwdata_i[7:0];
        ppl_pkg::IDX_PD4:  nxt_lat4 = pwdata_i[7:0];
        ppl_pkg::IDX_PD5:  nxt_lat5 = pwdata_i[7:0];
        ppl_pkg::IDX_PD6:  nxt_lat6 = pwdata_i[7:0];
        ppl_pkg::IDX_BZR:  nxt_bzr  = pwdata_i[2:0];
        default: ;
      endcase
    end
    // Read data captured in the setup phase, stable through access
    if (setup) begin
      nxt_prdata = 32'h0;
      nxt_err    = 1'b0;
      if (idx[5] && !pwrite_i) begin
        unique case (idx & ~ppl_pkg::IDX_LVIEW)
          ppl_pkg::IDX_PD0: nxt_prdata[7:0] = lat0_ff;
          ppl_pkg::IDX_PD1: nxt_prdata[7:0] = lat1_ff;
          ppl_pkg::IDX_PD3: nxt_prdata[7:0] = lat3_ff;
          default:          nxt_err = 1'b1;
        endcase
      end else if (!known_idx(idx)) begin
        nxt_err = 1'b1;
      end else if (!pwrite_i) begin
        unique case (idx)
          // Pin levels, peripheral output when it drives
          ppl_pkg::IDX_PD0: nxt_prdata[7:0] = port_rd(pin0, res0_i);
          ppl_pkg::IDX_PD1: nxt_prdata[7:0] = port_rd(pin1, res1_i);
          ppl_pkg::IDX_PD3: nxt_prdata[7:0] = port_rd(pin3, res3_i);
          ppl_pkg::IDX_PD2: nxt_prdata[3:0] = lat2_ff;
          ppl_pkg::IDX_PD4: nxt_prdata[7:0] = lat4_ff;
          ppl_pkg::IDX_PD5: nxt_prdata[7:0] = lat5_ff;
          ppl_pkg::IDX_PD6: nxt_prdata[7:0] = lat6_ff;
          ppl_pkg::IDX_PD7: nxt_prdata[1:0] = pin7;
          ppl_pkg::IDX_BZR: nxt_prdata[2:0] = bzr_ff;
          default: nxt_prdata = 32'h0;
        endcase
      end else if (idx == ppl_pkg::IDX_PD7) begin
        nxt_err = 1'b1;
      end
    end
    if (srst_i) begin
      nxt_dir0    = ppl_pkg::RST_DIR;
      nxt_dir1    = ppl_pkg::RST_DIR;
      nxt_dir3    = ppl_pkg::RST_DIR;
      // Output-only latch cleared, drivers off until fetch
      nxt_lat2    = ppl_pkg::RST_PD2;
      nxt_fetched = 1'b0;
      nxt_lat4    = ppl_pkg::RST_HV;
      nxt_lat5    = ppl_pkg::RST_HV;
      nxt_lat6    = ppl_pkg::RST_HV;
      nxt_bzr     = ppl_pkg::RST_BZR;
      nxt_bzc     = '0;
      nxt_prdata  = 32'h0;
      nxt_err     = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    dir0_ff    <= nxt_dir0;
    dir1_ff    <= nxt_dir1;
    dir3_ff    <= nxt_dir3;
    lat0_ff    <= nxt_lat0;
    lat1_ff    <= nxt_lat1;
    lat3_ff    <= nxt_lat3;
    lat2_ff    <= nxt_lat2;
    lat4_ff    <= nxt_lat4;
    lat5_ff    <= nxt_lat5;
    lat6_ff    <= nxt_lat6;
    bzr_ff     <= nxt_bzr;
    fetched_ff <= nxt_fetched;
    bzc_ff     <= nxt_bzc;
    prdata_ff  <= nxt_prdata;
    err_ff     <= nxt_err;
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & err_ff;

  // Per-bit direction, peripheral enable wins except on the open-drain bit, float
  always_comb begin
    p0_o.o  = (res0_i.oe & res0_i.o) | (~res0_i.oe & lat0_ff);
    p0_o.oe = float_en ? 8'h00 : (dir0_ff | res0_i.oe);
    p1_o.o  = (res1_i.oe & res1_i.o) | (~res1_i.oe & lat1_ff);
    p1_o.oe = float_en ? 8'h00 : (dir1_ff | res1_i.oe);
    p3_o.o  = (res3_i.oe & res3_i.o) | (~res3_i.oe & lat3_ff);
    p3_o.oe = float_en ? 8'h00 : (dir3_ff | res3_i.oe);
    // N-ch open-drain bit only pulls low
    p3_o.oe[ppl_pkg::P31_BIT] = ~float_en & dir3_ff[ppl_pkg::P31_BIT] & ~lat3_ff[ppl_pkg::P31_BIT];
    p3_o.o[ppl_pkg::P31_BIT]  = 1'b0;
  end

  // Pin level always reaches the peripheral
  assign res0_in_o = pin0;
  assign res1_in_o = pin1;
  assign res3_in_o = pin3;

  assign p2_o    = lat2_ff;
  assign p2_oe_o = (fetched_ff & ~float_en) ? 4'hf : 4'h0;

  // P-ch open drain pulls high where latch is 1
  assign p4_o.o  = 8'hff;
  assign p4_o.oe = float_en ? 8'h00 : lat4_ff;
  assign p5_o.o  = 8'hff;
  assign p5_o.oe = float_en ? 8'h00 : lat5_ff;
  assign p6_o.o  = 8'hff;
  assign p6_o.oe = float_en ? 8'h00 : lat6_ff;

  // Oscillator pass-through only with dual clock option
  assign sub_osc_o = dual_clock_opt_i ? pin7 : 2'h0;

  // Waveform tap chosen by register; zero floats the pin
  assign bz_wave         = bzc_ff[ppl_pkg::BZ_BASE + int'(bzr_ff)];
  assign buzzer_pin_o    = 1'b1;
  assign buzzer_pin_oe_o = (bzr_ff != 3'h0) & bz_wave & ~float_en;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_wr_pd0;
    wr && idx == ppl_pkg::IDX_PD0;
  endsequence
  property p_latch_write;
    s_wr_pd0 |=> lat0_ff == $past(pwdata_i[7:0]);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch not written");
  property p_float;
    float_en |-> (p0_o.oe == 8'h00 && p1_o.oe == 8'h00 && p3_o.oe == 8'h00 && p4_o.oe == 8'h00 &&
                  p5_o.oe == 8'h00 && p6_o.oe == 8'h00 && p2_oe_o == 4'h0 && !buzzer_pin_oe_o);
  endproperty
  a_float: assert property (p_float) else $error("output not floated");
  property p_override;
    !float_en |-> ((p1_o.oe & res1_i.oe) == res1_i.oe) && ((p1_o.o & res1_i.oe) == (res1_i.o & res1_i.oe));
  endproperty
  a_override: assert property (p_override) else $error("driver enable wrong");
  property p_dir_reset;
    // Own disable: the default one would mask every reset attempt
    @(posedge clk_i) disable iff (1'b0) srst_i |=> dir0_ff == 8'h00 && dir3_ff == 8'h00 && !fetched_ff;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");
  property p_hv_read;
    setup && !pwrite_i && idx == ppl_pkg::IDX_PD5 |=> prdata_o[7:0] == $past(lat5_ff);
  endproperty
  a_hv_read: assert property (p_hv_read) else $error("hv read not latch");
  property p_p2_read;
    setup && !pwrite_i && idx == ppl_pkg::IDX_PD2 |=> prdata_o == {28'h0, $past(lat2_ff)};
  endproperty
  a_p2_read: assert property (p_p2_read) else $error("port2 read wrong");
  property p_dir_wo;
    setup && !pwrite_i && idx == ppl_pkg::IDX_DIR0 |=> prdata_o == 32'h0;
  endproperty
  a_dir_wo: assert property (p_dir_wo) else $error("direction readable");
  property p_bz_off;
    bzr_ff == 3'h0 |-> !buzzer_pin_oe_o;
  endproperty
  a_bz_off: assert property (p_bz_off) else $error("buzzer driven at zero");
  property p_rmw;
    setup && !pwrite_i && idx == (ppl_pkg::IDX_LVIEW | ppl_pkg::IDX_PD3) |=> prdata_o[7:0] == $past(lat3_ff);
  endproperty
  a_rmw: assert property (p_rmw) else $error("latch view wrong");
  property p_p2_fetch;
    !fetched_ff ##1 !fetched_ff |-> p2_oe_o == 4'h0;
  endproperty
  a_p2_fetch: assert property (p_p2_fetch) else $error("port2 driven early");
endmodule // ppl_top

// ---- tb/ppl_board.sv ----
// Purpose: Board model resolving the pins of ports 0, 1 and 3
// Assumes: No pull resistors; undriven pins follow the external level
// Notes:   Levels are raw pin levels, the design does its own syncing
`timescale 1ns/1ps
module ppl_board (
  // Design drive
  input  ppl_pkg::ppl_drv_t p0_i,
  input  ppl_pkg::ppl_drv_t p1_i,
  input  ppl_pkg::ppl_drv_t p3_i,
  // External levels
  input  wire logic [7:0]   ext0_i,
  input  wire logic [7:0]   ext1_i,
  input  wire logic [7:0]   ext3_i,
  // Resolved pins
  output logic [7:0]        pin0_o,
  output logic [7:0]        pin1_o,
  output logic [7:0]        pin3_o
);
  assign pin0_o = (p0_i.oe & p0_i.o) | (~p0_i.oe & ext0_i);
  assign pin1_o = (p1_i.oe & p1_i.o) | (~p1_i.oe & ext1_i);
  assign pin3_o = (p3_i.oe & p3_i.o) | (~p3_i.oe & ext3_i);
endmodule // ppl_board

// ---- tb/ppl_top_bench.sv ----
// Purpose: Self-checking bench for the port pin logic
// Assumes: APB slave answers with pready, pins synced in two clocks
// Notes:   Directed scenarios only
`timescale 1ns/1ps
module ppl_top_bench;
  logic clk_i, srst_i, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, ext0, ext1, ext3, pin0, pin1, pin3, rin0, rin1, rin3;
  logic [31:0] pwdata, prdata, rd;
  logic stop_float, stop_mode, vfetch, dual, bz, bz_oe;
  logic [3:0] p2, p2_oe;
  logic [1:0] p7, sosc;
  ppl_pkg::ppl_res_t res0, res1, res3;
  ppl_pkg::ppl_drv_t p0, p1, p3, p4, p5, p6;
  int n_errors, comparisons;

  ppl_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .stop_float_bit_i(stop_float),
    .stop_mode_i(stop_mode), .vector_fetch_i(vfetch), .dual_clock_opt_i(dual),
    .p0_in_i(pin0), .p1_in_i(pin1), .p3_in_i(pin3), .p0_o(p0), .p1_o(p1), .p3_o(p3),
    .res0_i(res0), .res1_i(res1), .res3_i(res3), .res0_in_o(rin0), .res1_in_o(rin1),
    .res3_in_o(rin3), .p2_o(p2), .p2_oe_o(p2_oe), .p4_o(p4), .p5_o(p5), .p6_o(p6),
    .p7_in_i(p7), .sub_osc_o(sosc), .buzzer_pin_o(bz), .buzzer_pin_oe_o(bz_oe));
  ppl_board i_board (.p0_i(p0), .p1_i(p1), .p3_i(p3), .ext0_i(ext0), .ext1_i(ext1),
    .ext3_i(ext3), .pin0_o(pin0), .pin1_o(pin1), .pin3_o(pin3));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task end_sim;
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      chk(pready, 32'h1);
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task look;
    @(negedge clk_i);
  endtask

  task do_reset(input int n);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    srst_i <= 1'b0;
    look();
  endtask

  task t_bidir;
    @(posedge clk_i);
    ext0 <= 8'h3c;
    apb(1'b1, ppl_pkg::IDX_PD0, 32'ha5);
    look();
    chk(p0.oe, 32'h0);
    apb(1'b0, ppl_pkg::IDX_LVIEW | ppl_pkg::IDX_PD0, 32'h0);
    chk(rd, 32'ha5);
    apb(1'b0, ppl_pkg::IDX_PD0, 32'h0);
    chk(rd, 32'h3c);
    apb(1'b1, ppl_pkg::IDX_DIR0, 32'h0f);
    look();
    chk({p0.oe, p0.o & 8'h0f}, 32'h0f05);
    repeat (3) look();
    apb(1'b0, ppl_pkg::IDX_PD0, 32'h0);
    chk(rd, 32'h35);
    chk(rin0, 32'h35);
    apb(1'b0, ppl_pkg::IDX_DIR0, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, ppl_pkg::IDX_PD0, 32'h5a);
    look();
    chk(p0.o, 32'h5a);
  endtask

  task t_reset;
    do_reset(3);
    chk({p0.oe, p1.oe, p3.oe}, 32'h0);
    chk({p2_oe, p2}, 32'h0);
    chk({p4.oe, p5.oe, p6.oe}, 32'h0);
    chk(bz_oe, 32'h0);
    apb(1'b0, ppl_pkg::IDX_LVIEW | ppl_pkg::IDX_PD0, 32'h0);
    chk(rd, 32'h5a);
    @(posedge clk_i);
    vfetch <= 1'b1;
    @(posedge clk_i);
    vfetch <= 1'b0;
    look();
    chk({p2_oe, p2}, 32'hf0);
  endtask

  task t_ports;
    apb(1'b1, ppl_pkg::IDX_PD2, 32'h9);
    look();
    chk(p2, 32'h9);
    apb(1'b0, ppl_pkg::IDX_PD2, 32'h0);
    chk(rd, 32'h9);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 6'(ppl_pkg::IDX_PD4 + i), 32'h5a ^ i);
      apb(1'b0, 6'(ppl_pkg::IDX_PD4 + i), 32'h0);
      chk(rd, 32'h5a ^ i);
    end
    look();
    chk({p4.oe, p5.oe, p6.oe}, 32'h5a5b58);
  endtask

  task t_shared;
    @(posedge clk_i);
    ext1 <= 8'h55;
    ext3 <= 8'hff;
    res1 <= '{oe: 8'h80, o: 8'h80};
    look();
    chk({p1.oe[7], p1.o[7]}, 32'h3);
    repeat (3) look();
    apb(1'b0, ppl_pkg::IDX_PD1, 32'h0);
    chk(rd, 32'hd5);
    chk(rin1, 32'hd5);
    // Open-drain bit only pulls low when its latch is 0
    apb(1'b1, ppl_pkg::IDX_PD3, 32'hff);
    apb(1'b1, ppl_pkg::IDX_DIR3, 32'h02);
    look();
    chk(p3.oe, 32'h0);
    apb(1'b1, ppl_pkg::IDX_PD3, 32'h0);
    repeat (3) look();
    chk({p3.oe, p3.o[1]}, 32'h4);
    chk(rin3, 32'hfd);
    apb(1'b0, ppl_pkg::IDX_LVIEW | ppl_pkg::IDX_PD3, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ppl_pkg::IDX_PD3, 32'h0);
    chk(rd, 32'hfd);
  endtask

  task t_input;
    @(posedge clk_i);
    p7 <= 2'b10;
    dual <= 1'b1;
    repeat (3) look();
    chk(sosc, 32'h2);
    apb(1'b0, ppl_pkg::IDX_PD7, 32'h0);
    chk(rd, 32'h2);
    chk(er, 32'h0);
    apb(1'b1, ppl_pkg::IDX_PD7, 32'h3);
    chk(er, 32'h1);
    apb(1'b0, 6'h3f, 32'h0);
    chk(er, 32'h1);
  endtask

  task t_float;
    int s0, s1;
    s0 = 0;
    s1 = 0;
    apb(1'b1, ppl_pkg::IDX_DIR0, 32'hff);
    apb(1'b1, ppl_pkg::IDX_BZR, 32'h1);
    repeat (2100) begin
      look();
      s0 += int'(bz_oe === 1'b0);
      s1 += int'(bz_oe === 1'b1);
    end
    chk({s0 > 0, s1 > 0}, 32'h3);
    chk(bz, 32'h1);
    @(posedge clk_i);
    stop_float <= 1'b1;
    look();
    chk(p0.oe, 32'hff);
    @(posedge clk_i);
    stop_mode <= 1'b1;
    s1 = 0;
    repeat (1100) begin
      look();
      s1 += int'(bz_oe !== 1'b0);
    end
    chk({p0.oe, p4.oe, p2_oe, 3'h0, bz_oe}, 32'h0);
    chk(s1, 32'h0);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {stop_float, stop_mode, vfetch, dual, p7} = '0;
    {ext0, ext1, ext3} = '0;
    {res0, res1, res3} = '0;
    n_errors = 0;
    comparisons = 0;
    srst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    t_bidir();
    t_reset();
    t_ports();
    t_shared();
    t_input();
    t_float();
    end_sim();
  end
endmodule // ppl_top_bench
